// file: logic/sfms_defs.svh
// Purpose: shared constants of the synchronous flash mode setup block
// Assumes: included by bare name from the package and the bench
// Notes:   definitions only
`ifndef SFMS_DEFS_SVH
`define SFMS_DEFS_SVH

// ----------------------------------------
// operation mode register fields
// ----------------------------------------
`define SFMS_MODE_RESET    8'h62
`define SFMS_BL_MSB        1
`define SFMS_BL_LSB        0
`define SFMS_BT_BIT        2
`define SFMS_CL_MSB        5
`define SFMS_CL_LSB        3
`define SFMS_RL_BIT        6
`define SFMS_RM_BIT        7
`define SFMS_BL4_CODE      2'h2
`define SFMS_BL8_CODE      2'h3
`define SFMS_BOOT_KEY_BIT  8

// ----------------------------------------
// timing
// ----------------------------------------
`define SFMS_MODE_CYCLES   2'h3

// ----------------------------------------
// controller register map
// ----------------------------------------
`define SFMS_REG_CTRL      4'h0
`define SFMS_REG_CMD       4'h1
`define SFMS_REG_STATUS    4'h2
`define SFMS_REG_RDATA     4'h3
`define SFMS_CTRL_PD_BIT   0
`define SFMS_CMD_OP_MSB    1
`define SFMS_CMD_OP_LSB    0
`define SFMS_CMD_ADDR_MSB  20
`define SFMS_CMD_ADDR_LSB  8

`endif

// file: logic/sfms_pkg.sv
// Purpose: types and field decode shared by both ends
// Assumes: sfms_defs.svh holds the numbers
// Notes:   none
package sfms_pkg;
`include "sfms_defs.svh"

	typedef enum logic [1:0] {
		SFMS_OP_NOP  = 2'b00,
		SFMS_OP_ROW  = 2'b01,
		SFMS_OP_READ = 2'b10,
		SFMS_OP_MODE = 2'b11
	} sfms_op_t;

	typedef enum logic {
		SFMS_DEV_READY = 1'b0,
		SFMS_DEV_BUSY  = 1'b1
	} sfms_dev_state_t;

	typedef enum logic [1:0] {
		SFMS_HOST_PWRUP = 2'b00,
		SFMS_HOST_IDLE  = 2'b01,
		SFMS_HOST_MWAIT = 2'b10
	} sfms_host_state_t;

	// cas latency in cycles, code 0 reads as 1
	function automatic logic [3:0] sfms_cas_lat(input logic [7:0] m);
		return {1'b0, m[`SFMS_CL_MSB:`SFMS_CL_LSB]} + 4'h1;
	endfunction

	function automatic logic [1:0] sfms_ras_lat(input logic [7:0] m);
		return m[`SFMS_RL_BIT] ? 2'h2 : 2'h1;
	endfunction

	function automatic logic sfms_bl8(input logic [7:0] m);
		return m[`SFMS_BL_MSB:`SFMS_BL_LSB] == `SFMS_BL8_CODE;
	endfunction

	function automatic logic sfms_mode_legal(input logic [7:0] m);
		return (m[`SFMS_BL_MSB:`SFMS_BL_LSB] == `SFMS_BL4_CODE || sfms_bl8(m))
			&& m[`SFMS_CL_MSB:`SFMS_CL_LSB] != 3'h0;
	endfunction
endpackage

// file: logic/sfms_bus_if.sv
// Purpose: synchronous memory bus between controller and flash
// Assumes: both ends run on the same CLK
// Notes:   dq is driven by the flash at all times, valid only while dq_oe is high
`timescale 1ns/1ns
interface sfms_bus_if;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        mls_n;
	logic        cke;
	logic        dqm;
	logic        word;
	logic [12:0] addr;
	logic [31:0] dq;
	logic        dq_oe;

	modport dev (
		input  cs_n, ras_n, cas_n, mls_n, cke, dqm, word, addr,
		output dq, dq_oe
	);
	modport host (
		output cs_n, ras_n, cas_n, mls_n, cke, dqm, word, addr,
		input  dq, dq_oe
	);
endinterface

// file: logic/sfms_burst_gen.sv
// Purpose: beat offset inside a wrapped burst
// Assumes: start and beat are low column bits
// Notes:   combinational
`timescale 1ns/1ns
module sfms_burst_gen (
	// burst setup
	input  wire logic [2:0] start,
	input  wire logic [2:0] beat,
	input  wire logic       bl8,
	input  wire logic       interleave,
	// result
	output logic      [2:0] offset
);
	logic [2:0] raw;

	always_comb begin
		raw = interleave ? (start ^ beat) : (start + beat); // R15
		// a 4-beat burst wraps inside its aligned quad
		offset = bl8 ? raw : {start[2], raw[1:0]}; // R15
	end
endmodule

// file: logic/sfms_device.sv
// Function
// R1: chip select high makes cycle nop
// R2: no mode load during normal operation
// R3: power-up holds strobes, enable, mask high
// R4: width select set at power-up, kept
// R5: mode update takes three cycles
// R6: data outputs float unless reading
// R7: variant auto-selects boot region after power-up
// R8: width select high x32, low x16
// R9: row on row strobe, column on column strobe
// R10: reset mode: array, RL2, CL5, BL4, sequential
// R11: mode load after power-down exit, before operation
// R12: mode load: all four strobes low, active
// R13: mode load captures address bits 0..7
// R14: mode fields: length, type, CL, RL, read
// R15: burst order sequential or interleaved wrap
// R16: controller writes only non-reserved mode codes
//
// Purpose: flash end of the bus, command decode and mode setup
// Assumes: controller on the same clock, array read combinationally
// Notes:   ARRAY_DATA must answer ARRAY_ADDR within the same cycle
`timescale 1ns/1ns
module sfms_device
	import sfms_pkg::*;
#(
	parameter logic        BOOT_AUTO  = 1'b0,
	parameter logic [31:0] PRODUCT_ID = 32'h0000_5A5A // arbitrary value
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET,
	// memory bus
	sfms_bus_if.dev          bus,
	// array side
	output logic      [19:0] ARRAY_ADDR,
	input  wire logic [31:0] ARRAY_DATA,
	// status
	output logic      [7:0]  MODE,
	output logic             READY,
	output logic             BOOT_SEL,
	output logic             X32,
	output logic             ROW_OPEN,
	output logic             ILLEGAL
);
	typedef struct packed {
		sfms_dev_state_t fsm;
		logic [1:0]      wait_cnt;
		logic [7:0]      mode;
		logic            boot;
		logic            x32;
		logic            cke_q;
		logic            dqm_q;
		logic            row_open;
		logic [1:0]      row_age;
		logic [12:0]     row;
		logic [7:0]      col;
		logic [2:0]      start;
		logic            burst;
		logic [2:0]      lat;
		logic [2:0]      beat;
		logic [19:0]     arr_addr;
		logic            hi_half;
		logic [31:0]     dq;
		logic            dq_oe;
		logic            illegal;
	} sfms_dev_st_t;

	sfms_dev_st_t st;
	sfms_dev_st_t next_st;

	logic       cmd_en;
	logic       mode_cmd;
	logic       row_cmd;
	logic       rd_cmd;
	logic [2:0] gen_start;
	logic [2:0] gen_beat;
	logic [2:0] gen_off;
	logic [7:0] src_col;
	logic [7:0] new_col;

	// --------------------------------------------------
	// burst address
	// --------------------------------------------------
	function automatic logic [7:0] wrap_col(input logic [7:0] c, input logic [2:0] off,
		input logic bl8);
		return bl8 ? {c[7:3], off} : {c[7:2], off[1:0]};
	endfunction

	sfms_burst_gen sfms_burst_gen_i (
		.start      (gen_start),
		.beat       (gen_beat),
		.bl8        (sfms_bl8(st.mode)),
		.interleave (st.mode[`SFMS_BT_BIT]),
		.offset     (gen_off)
	);

	// --------------------------------------------------
	// command decode
	// --------------------------------------------------
	always_comb begin
		cmd_en = st.cke_q && !bus.cs_n; // R1
		mode_cmd = cmd_en && !bus.ras_n && !bus.cas_n && !bus.mls_n; // R12
		row_cmd = cmd_en && !bus.ras_n && bus.cas_n && bus.mls_n; // R9
		// column strobe is honoured only after the ras latency
		rd_cmd = cmd_en && bus.ras_n && !bus.cas_n && bus.mls_n && st.row_open
			&& st.row_age >= sfms_ras_lat(st.mode) && st.fsm == SFMS_DEV_READY; // R9
		// interleave needs the first column as anchor, not the last beat
		gen_start = rd_cmd ? bus.addr[2:0] : st.start; // R15
		gen_beat = rd_cmd ? 3'h0 : st.beat + 3'h1;
		src_col = rd_cmd ? bus.addr[7:0] : st.col;
		new_col = wrap_col(src_col, gen_off, sfms_bl8(st.mode)); // R15
	end

	// --------------------------------------------------
	// next state
	// --------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.cke_q = bus.cke;
		next_st.x32 = bus.word; // R8
		// with clock enable low everything but cke_q and x32 stays frozen, dq and dq_oe included
		if (st.cke_q) begin
			next_st.dqm_q = bus.dqm;
			next_st.dq_oe = 1'b0; // R6
			if (st.row_open && st.row_age != 2'h2) begin
				next_st.row_age = st.row_age + 2'h1;
			end
			if (st.burst) begin
				if (st.lat > 3'h1) begin
					next_st.lat = st.lat - 3'h1;
				end else begin
					if (st.mode[`SFMS_RM_BIT]) begin // R14
						next_st.dq = PRODUCT_ID;
					end else if (st.x32) begin
						next_st.dq = ARRAY_DATA;
					end else begin
						next_st.dq = {16'h0000, st.hi_half ? ARRAY_DATA[31:16]
							: ARRAY_DATA[15:0]};
					end
					// mask sampled two edges before the data is seen
					next_st.dq_oe = !st.dqm_q; // R6
					next_st.beat = st.beat + 3'h1;
					if (st.beat == (sfms_bl8(st.mode) ? 3'h7 : 3'h3)) begin
						next_st.burst = 1'b0;
					end
					next_st.col = new_col;
					next_st.arr_addr = st.x32 ? {st.row, new_col[6:0]}
						: {st.row, new_col[7:1]};
					next_st.hi_half = !st.x32 && new_col[0];
				end
			end
			case (st.fsm)
				SFMS_DEV_BUSY: begin
					// commands are dropped while the mode register settles
					if (st.wait_cnt == 2'h1) begin // R5
						next_st.fsm = SFMS_DEV_READY;
					end else begin
						next_st.wait_cnt = st.wait_cnt - 2'h1;
					end
				end
				SFMS_DEV_READY: begin
					if (mode_cmd) begin
						// loading during operation leaves an undefined state
						if (st.row_open || st.burst) begin // R2
							next_st.illegal = 1'b1;
						end
						next_st.mode = bus.addr[7:0]; // R13
						next_st.boot = bus.addr[`SFMS_BOOT_KEY_BIT]; // R7
						next_st.fsm = SFMS_DEV_BUSY;
						next_st.wait_cnt = `SFMS_MODE_CYCLES - 2'h1; // R5
					end else if (row_cmd) begin
						next_st.row = bus.addr; // R9
						next_st.row_open = 1'b1;
						next_st.row_age = 2'h1;
					end else if (rd_cmd) begin
						next_st.col = new_col; // R9
						next_st.start = bus.addr[2:0]; // R15
						next_st.burst = 1'b1;
						next_st.beat = 3'h0;
						next_st.lat = 3'(sfms_cas_lat(st.mode) - 4'h1); // R14
						next_st.arr_addr = st.x32 ? {st.row, new_col[6:0]}
							: {st.row, new_col[7:1]}; // R8
						next_st.hi_half = !st.x32 && new_col[0];
					end
				end
				default: begin
					next_st.fsm = SFMS_DEV_READY;
				end
			endcase
		end
	end

	// --------------------------------------------------
	// state register
	// --------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			st <= '0;
			st.mode <= `SFMS_MODE_RESET; // R10
			st.boot <= BOOT_AUTO; // R7
			st.x32 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// --------------------------------------------------
	// outputs
	// --------------------------------------------------
	assign bus.dq     = st.dq;
	assign bus.dq_oe  = st.dq_oe;
	assign ARRAY_ADDR = st.arr_addr;
	assign MODE       = st.mode;
	assign READY      = st.fsm == SFMS_DEV_READY;
	assign BOOT_SEL   = st.boot;
	assign X32        = st.x32;
	assign ROW_OPEN   = st.row_open;
	assign ILLEGAL    = st.illegal;
endmodule

// file: logic/sfms_host.sv
// Purpose: controller end of the bus, driven from software registers
// Assumes: one register access per strobe, read data one cycle later
// Notes:   width select is fixed by parameter
`timescale 1ns/1ns
module sfms_host
	import sfms_pkg::*;
#(
	parameter int   POWERUP_CYCLES = 16,
	parameter logic WORD_X32       = 1'b1
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET,
	// register port
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	// memory bus
	sfms_bus_if.host         bus
);
	typedef struct packed {
		sfms_host_state_t fsm;
		logic [15:0]      cnt;
		logic             pd;
		logic             refused;
		logic             row_open;
		logic             cs_n;
		logic             ras_n;
		logic             cas_n;
		logic             mls_n;
		logic             dqm;
		logic [12:0]      addr;
		logic [31:0]      rdata;
		logic [31:0]      reg_rdata;
	} sfms_host_st_t;

	sfms_host_st_t st;
	sfms_host_st_t next_st;
	sfms_op_t      op;
	logic [12:0]   op_addr;
	logic          cmd_wr;

	// --------------------------------------------------
	// next state
	// --------------------------------------------------
	always_comb begin
		next_st = st;
		op = sfms_op_t'(REG_WDATA[`SFMS_CMD_OP_MSB:`SFMS_CMD_OP_LSB]);
		op_addr = REG_WDATA[`SFMS_CMD_ADDR_MSB:`SFMS_CMD_ADDR_LSB];
		cmd_wr = REG_WR && REG_ADDR == `SFMS_REG_CMD;
		// every command lasts one cycle, then the bus returns to nop
		next_st.cs_n = 1'b1;
		next_st.ras_n = 1'b1;
		next_st.cas_n = 1'b1;
		next_st.mls_n = 1'b1;
		if (bus.dq_oe) begin
			next_st.rdata = bus.dq;
		end
		if (REG_WR && REG_ADDR == `SFMS_REG_CTRL) begin
			next_st.pd = REG_WDATA[`SFMS_CTRL_PD_BIT]; // R11
		end
		case (st.fsm)
			SFMS_HOST_PWRUP: begin
				if (st.cnt == 16'h0001) begin // R3
					next_st.fsm = SFMS_HOST_IDLE;
					next_st.dqm = 1'b0;
				end else begin
					next_st.cnt = st.cnt - 16'h0001;
				end
				if (cmd_wr) begin
					next_st.refused = 1'b1;
				end
			end
			SFMS_HOST_MWAIT: begin
				if (st.cnt == 16'h0001) begin // R5
					next_st.fsm = SFMS_HOST_IDLE;
				end else begin
					next_st.cnt = st.cnt - 16'h0001;
				end
				if (cmd_wr) begin
					next_st.refused = 1'b1;
				end
			end
			SFMS_HOST_IDLE: begin
				if (cmd_wr) begin
					next_st.refused = 1'b0;
					next_st.addr = op_addr;
					case (op)
						SFMS_OP_MODE: begin
							// R2 R11 R16
							if (st.row_open || st.pd || !sfms_mode_legal(op_addr[7:0])) begin
								next_st.refused = 1'b1;
							end else begin
								next_st.cs_n = 1'b0; // R12
								next_st.ras_n = 1'b0;
								next_st.cas_n = 1'b0;
								next_st.mls_n = 1'b0;
								next_st.fsm = SFMS_HOST_MWAIT;
								next_st.cnt = {14'h0000, `SFMS_MODE_CYCLES}; // R5
							end
						end
						SFMS_OP_ROW: begin
							if (st.pd) begin
								next_st.refused = 1'b1;
							end else begin
								next_st.cs_n = 1'b0; // R9
								next_st.ras_n = 1'b0;
								next_st.row_open = 1'b1;
							end
						end
						SFMS_OP_READ: begin
							if (st.pd || !st.row_open) begin
								next_st.refused = 1'b1;
							end else begin
								next_st.cs_n = 1'b0; // R9
								next_st.cas_n = 1'b0;
							end
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				next_st.fsm = SFMS_HOST_IDLE;
			end
		endcase
		next_st.reg_rdata = 32'h0000_0000;
		if (REG_RD) begin
			case (REG_ADDR)
				`SFMS_REG_CTRL:   next_st.reg_rdata = {31'h0, st.pd};
				`SFMS_REG_STATUS: next_st.reg_rdata = {28'h0, st.row_open, st.refused,
					st.fsm == SFMS_HOST_IDLE, st.fsm != SFMS_HOST_IDLE};
				`SFMS_REG_RDATA:  next_st.reg_rdata = st.rdata;
				default:          next_st.reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	// --------------------------------------------------
	// state register
	// --------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			st <= '0;
			st.cnt <= 16'(POWERUP_CYCLES); // R3
			st.cs_n <= 1'b1;
			st.ras_n <= 1'b1;
			st.cas_n <= 1'b1;
			st.mls_n <= 1'b1;
			st.dqm <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// --------------------------------------------------
	// outputs
	// --------------------------------------------------
	assign bus.cs_n  = st.cs_n;
	assign bus.ras_n = st.ras_n;
	assign bus.cas_n = st.cas_n;
	assign bus.mls_n = st.mls_n;
	assign bus.cke   = !st.pd;
	assign bus.dqm   = st.dqm;
	assign bus.word  = WORD_X32; // R4
	assign bus.addr  = st.addr;
	assign REG_RDATA = st.reg_rdata;
endmodule

// file: bench/sfms_bus_assertions.sv
// Purpose: wire checks between the controller and flash ends
// Assumes: one clock, synchronous active-high reset
// Notes:   sits beside the bus interface, no bind
`timescale 1ns/1ns
module sfms_bus_assertions (
	// clock and reset
	input wire logic        CLK,
	input wire logic        RESET,
	// command lines
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        mls_n,
	input wire logic        cke,
	input wire logic        dqm,
	input wire logic        word,
	input wire logic [12:0] addr,
	// data enable
	input wire logic        dq_oe
);
	wire logic  rd_c  = !cs_n && ras_n && !cas_n && mls_n;
	wire logic  row_c = !cs_n && !ras_n && cas_n && mls_n;
	logic [4:0] since_rd;
	logic       row_seen;

	// saturates so a stray enable long after reset still fails
	always_ff @(posedge CLK) begin
		if (RESET) begin
			since_rd <= 5'h1F;
			row_seen <= 1'b0;
		end else begin
			if (rd_c)
				since_rd <= 5'h01;
			else if (since_rd != 5'h1F)
				since_rd <= since_rd + 5'h01;
			if (row_c)
				row_seen <= 1'b1;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence mode_s;
		!cs_n && !ras_n && !cas_n && !mls_n;
	endsequence
	sequence quiet3_s;
		cs_n [*3];
	endsequence

	powerup_hold_a: assert property ($fell(RESET) |-> mls_n && cke && dqm && cs_n)
		else $error("power-up levels wrong");
	word_fixed_a: assert property ($stable(word))
		else $error("width select moved");
	mode_wait_a: assert property (mode_s |=> quiet3_s)
		else $error("command inside mode update");
	mode_strobes_a: assert property (!mls_n |-> !cs_n && !ras_n && !cas_n && $past(cke))
		else $error("mode strobe without full command");
	mode_codes_a: assert property (mode_s |-> addr[1] && addr[5:3] != 3'h0)
		else $error("reserved mode code sent");
	late_mode_a: assert property (mode_s |-> !row_seen)
		else $error("mode load after row open");
	read_row_a: assert property (rd_c |-> row_seen)
		else $error("read before row");
	dq_quiet_a: assert property (dq_oe |-> since_rd inside {[2:15]})
		else $error("data driven outside a burst");
endmodule

// file: bench/sync_flash_mode_setup_bench.sv
// Purpose: both ends joined, driven through the controller registers
// Assumes: power-up shortened to 2 cycles, x32 width
// Notes:   array answers a tagged address so every beat is traceable
`timescale 1ns/1ns
`include "sfms_defs.svh"
module sync_flash_mode_setup_bench;
	localparam logic [31:0] PID = 32'h0000_3C3C; // arbitrary value
	logic        CLK = 1'b0;
	logic        RESET = 1'b1;
	logic [3:0]  REG_ADDR = 4'h0;
	logic [31:0] REG_WDATA = 32'h0;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	logic [19:0] ARRAY_ADDR;
	wire logic [31:0] ARRAY_DATA = {12'h5C3, ARRAY_ADDR};
	logic [7:0]  MODE;
	logic        READY, BOOT_SEL, X32, ROW_OPEN, ILLEGAL;
	logic        rd_q = 1'b0;
	logic [31:0] rq[$];
	logic [31:0] bq[$];
	int          fails = 0;
	int          n_tests = 0;

	always #4 CLK = ~CLK;

	sfms_bus_if sfms_bus_if_i ();
	sfms_host #(.POWERUP_CYCLES(2), .WORD_X32(1'b1)) sfms_host_i (.CLK(CLK), .RESET(RESET),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .bus(sfms_bus_if_i.host));
	sfms_device #(.BOOT_AUTO(1'b0), .PRODUCT_ID(PID)) sfms_device_i (.CLK(CLK),
		.RESET(RESET), .bus(sfms_bus_if_i.dev), .ARRAY_ADDR(ARRAY_ADDR),
		.ARRAY_DATA(ARRAY_DATA), .MODE(MODE), .READY(READY), .BOOT_SEL(BOOT_SEL),
		.X32(X32), .ROW_OPEN(ROW_OPEN), .ILLEGAL(ILLEGAL));
	sfms_bus_assertions sfms_bus_assertions_i (.CLK(CLK), .RESET(RESET),
		.cs_n(sfms_bus_if_i.cs_n), .ras_n(sfms_bus_if_i.ras_n), .cas_n(sfms_bus_if_i.cas_n),
		.mls_n(sfms_bus_if_i.mls_n), .cke(sfms_bus_if_i.cke), .dqm(sfms_bus_if_i.dqm),
		.word(sfms_bus_if_i.word), .addr(sfms_bus_if_i.addr), .dq_oe(sfms_bus_if_i.dq_oe));

	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// extra beats meet an unknown note and fail
	always @(posedge CLK) begin
		rd_q <= REG_RD;
		if (rd_q)
			chk(REG_RDATA, rq.pop_front());
		if (sfms_bus_if_i.dq_oe === 1'b1)
			chk(sfms_bus_if_i.dq, bq.size() ? bq.pop_front() : 32'hX);
	end

	// ----------------------------------------
	// register port driver
	// ----------------------------------------
	task automatic op(input logic [3:0] a, input logic [31:0] d, input logic w, input logic r);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= w;
		REG_RD <= r;
		@(posedge CLK);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		rq.push_back(e);
		op(a, 32'h0, 1'b0, 1'b1);
	endtask

	task automatic idle(input int n);
		repeat (n) op(4'h0, 32'h0, 1'b0, 1'b0);
	endtask

	initial begin
		logic [7:0]  m;
		logic [12:0] row;
		logic [6:0]  col, msk, cb;
		logic        b;
		logic [31:0] last;
		int          bl, i, k;
		void'($urandom(32'h476D63B0));
		repeat (16) @(posedge CLK);
		for (int it = 0; it < 6; it++) begin
			RESET <= 1'b0;
			idle(6);
			chk(MODE, 8'h62);
			chk({BOOT_SEL, X32, READY, sfms_bus_if_i.dq_oe}, 4'h6);
			rd(`SFMS_REG_STATUS, 32'h2);
			rd(4'hF, 32'h0);
			op(`SFMS_REG_CTRL, 32'h1, 1'b1, 1'b0);
			op(`SFMS_REG_CMD, 32'h6203, 1'b1, 1'b0);
			rd(`SFMS_REG_STATUS, 32'h6);
			op(`SFMS_REG_CTRL, 32'h0, 1'b1, 1'b0);
			op(`SFMS_REG_CMD, 32'h0, 1'b1, 1'b0);
			rd(`SFMS_REG_STATUS, 32'h2);
			op(`SFMS_REG_CMD, 32'h4003, 1'b1, 1'b0);
			rd(`SFMS_REG_STATUS, 32'h6);
			m = 8'($urandom);
			m[1] = 1'b1;
			if (m[5:3] == 3'h0)
				m[5:3] = 3'h1;
			b = 1'($urandom);
			row = 13'($urandom);
			col = 7'($urandom);
			// row right behind the mode load must be held off
			op(`SFMS_REG_CMD, {15'h0, b, m, 8'h03}, 1'b1, 1'b0);
			op(`SFMS_REG_CMD, {11'h0, row, 8'h01}, 1'b1, 1'b0);
			idle(1);
			chk(READY, 1'b0);
			idle(3);
			chk({BOOT_SEL, MODE, ROW_OPEN, READY}, {b, m, 1'b0, 1'b1});
			op(`SFMS_REG_CMD, {11'h0, row, 8'h01}, 1'b1, 1'b0);
			idle(3);
			rd(`SFMS_REG_STATUS, 32'hA);
			bl = m[0] ? 8 : 4;
			msk = 7'(bl - 1);
			for (k = 0; k < bl; k++) begin
				cb = m[2] ? (col ^ 7'(k)) : (col + 7'(k));
				last = m[7] ? PID : {12'h5C3, row, (col & ~msk) | (cb & msk)};
				bq.push_back(last);
			end
			op(`SFMS_REG_CMD, {17'h0, col, 8'h02}, 1'b1, 1'b0);
			i = 0;
			do begin
				idle(1);
				i++;
			end while (sfms_bus_if_i.dq_oe !== 1'b1 && i < 40);
			chk(i, m[5:3] + 2);
			if (i == 40)
				print_verdict();
			idle(12);
			chk(bq.size(), 0);
			rd(`SFMS_REG_RDATA, last);
			op(`SFMS_REG_CMD, {16'h0, m, 8'h03}, 1'b1, 1'b0);
			rd(`SFMS_REG_STATUS, 32'hE);
			idle(1);
			chk({MODE, ILLEGAL, ROW_OPEN}, {m, 1'b0, 1'b1});
			RESET <= 1'b1;
			idle(2);
		end
		print_verdict();
	end
endmodule
